// File: rtl/iop_ports.sv
// General-purpose port block: bidirectional port, fixed port, comparators, bus slave
////////////////////////////////////////////////////////////////////////////////////////////
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "iop_params.svh"
module iop_ports (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stop_recovery,
   input wire iop_pkg::iop_byte_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire iop_pkg::iop_word_t wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire iop_pkg::iop_byte_t araddr,
   input wire logic arvalid,
   output logic arready,
   output iop_pkg::iop_word_t rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire iop_pkg::iop_byte_t bidir_port_lines_in,
   input wire iop_pkg::iop_byte_t bidir_port_lines_driven,
   output iop_pkg::iop_byte_t bidir_port_lines_out,
   output iop_pkg::iop_byte_t bidir_port_lines_oe,
   input wire logic [2:0] aux_in,
   input wire logic [2:0] aux_in_driven,
   input wire logic comparator_a_out,
   input wire logic comparator_b_out,
   input wire iop_pkg::iop_byte_t wake_src,
   output logic aux_output_a,
   output logic aux_output_a_oe,
   output logic aux_output_b,
   output logic aux_output_b_oe,
   output logic aux_output_timer,
   input wire logic timer_output_line,
   output logic timer_input_line,
   output logic request_line_zero,
   output logic request_line_one,
   output logic request_line_two
);
   import iop_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////
   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   iop_byte_t waddr_reg, waddr_next, wbyte_reg, wbyte_next;
   logic wlane_reg, wlane_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   iop_word_t rdata_reg, rdata_next;
   logic do_write, wr_mapped, rd_mapped;
   iop_byte_t rd_byte;

   iop_byte_t bidir_data_reg, bidir_data_next, bidir_port_mode_reg, bidir_port_mode_next;
   iop_byte_t aux_port_mode_reg, aux_port_mode_next, port_config_reg, port_config_next;
   iop_byte_t interrupt_request_reg, interrupt_request_next;
   iop_byte_t stop_recovery_reg, stop_recovery_next, watchdog_mode_reg, watchdog_mode_next;
   logic [1:0] aux_data_reg, aux_data_next;
   logic timer_out_reg, timer_out_next;

   iop_byte_t bidir_s, wake_s;
   logic [4:0] aux_s;
   logic analog, a_val, b_val, ref_val, wake_act, route, aux_od;
   logic a_rise, a_fall, b_rise, b_fall;
   iop_edge_sel_t edge_sel;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Input conditioning: keeper then two flops on the port, aux, comparator and wake lines
   iop_sync_hold #(.W(8)) u_sync_bidir (.aclk(aclk), .aresetn(aresetn),
      .pin_in(bidir_port_lines_in), .driven(bidir_port_lines_driven), .level(bidir_s));
   // Comparator results always come from a live front end, so they are marked driven
   iop_sync_hold #(.W(5)) u_sync_aux (.aclk(aclk), .aresetn(aresetn),
      .pin_in({comparator_b_out, comparator_a_out, aux_in}),
      .driven({2'h3, aux_in_driven}), .level(aux_s));
   iop_sync_hold #(.W(8)) u_sync_wake (.aclk(aclk), .aresetn(aresetn), .pin_in(wake_src),
      .driven(8'hFF), .level(wake_s));

   ////////////////////////////////////////////////////////////////////////////////////////
   // Source selection and edge qualification
   assign analog = aux_port_mode_reg[`IOP_AUXM_ANALOG];
   assign a_val = analog ? aux_s[3] : aux_s[0];
   assign b_val = analog ? aux_s[4] : aux_s[1];
   // Polarity bit set asks for a high level from the chosen wake source
   assign wake_act = wake_s[stop_recovery_reg[`IOP_SMR_SRC_HI:`IOP_SMR_SRC_LO]]
                     ~^ stop_recovery_reg[`IOP_SMR_POL];
   assign ref_val = analog ? wake_act : aux_s[2];
   assign edge_sel = iop_edge_sel_t'(interrupt_request_reg[`IOP_IRQ_SEL_HI:`IOP_IRQ_SEL_LO]);
   assign a_rise = (edge_sel == EDGE_RISE_FALL) || (edge_sel == EDGE_BOTH);
   assign a_fall = (edge_sel != EDGE_RISE_FALL);
   assign b_rise = (edge_sel == EDGE_FALL_RISE) || (edge_sel == EDGE_BOTH);
   assign b_fall = (edge_sel != EDGE_FALL_RISE);

   iop_edge_det u_edge_a (.aclk(aclk), .aresetn(aresetn), .level(a_val), .rise_en(a_rise),
      .fall_en(a_fall), .pulse(request_line_two));
   iop_edge_det u_edge_b (.aclk(aclk), .aresetn(aresetn), .level(b_val), .rise_en(b_rise),
      .fall_en(b_fall), .pulse(request_line_zero));
   // Digital mode takes the falling edge of the pin; analog mode the wake source going active.
   // Switching mode may itself look like an edge: software should clear pending flags after.
   iop_edge_det u_edge_ref (.aclk(aclk), .aresetn(aresetn), .level(ref_val),
      .rise_en(analog), .fall_en(!analog), .pulse(request_line_one));

   ////////////////////////////////////////////////////////////////////////////////////////
   // Pin drive
   assign route = port_config_reg[`IOP_CFG_ROUTE];
   assign aux_od = port_config_reg[`IOP_CFG_AUX_OD];
   assign bidir_port_lines_out = bidir_data_reg;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         bidir_port_lines_oe[i] = !bidir_port_mode_reg[i] &&
            (!port_config_reg[`IOP_CFG_BIDIR_OD] || !bidir_data_reg[i]);
      end
   end
   assign aux_output_a = route ? aux_s[3] : aux_data_reg[0];
   assign aux_output_b = route ? aux_s[4] : aux_data_reg[1];
   assign aux_output_a_oe = !aux_od || !aux_output_a;
   assign aux_output_b_oe = !aux_od || !aux_output_b;
   assign aux_output_timer = timer_out_reg;
   assign timer_input_line = aux_s[0];

   ////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: one write and one read at a time, byte lane 0 carries the data
   assign awready = !aw_full_reg;
   assign wready = !w_full_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = !rvalid_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_mapped = (waddr_reg <= `IOP_OFF_STATUS) && (waddr_reg[1:0] == 2'h0);

   always_comb begin
      rd_mapped = 1'b1;
      unique case (araddr)
         `IOP_OFF_BIDIR_DATA: rd_byte = bidir_s;
         `IOP_OFF_BIDIR_MODE: rd_byte = bidir_port_mode_reg;
         `IOP_OFF_AUX_MODE: rd_byte = aux_port_mode_reg;
         `IOP_OFF_PORT_CFG: rd_byte = port_config_reg;
         `IOP_OFF_IRQ: rd_byte = interrupt_request_reg;
         `IOP_OFF_SMR: rd_byte = stop_recovery_reg;
         `IOP_OFF_WDT: rd_byte = watchdog_mode_reg;
         `IOP_OFF_AUX_DATA: rd_byte = {2'h0, aux_data_reg, 1'b0, ref_val, b_val, a_val};
         `IOP_OFF_STATUS: rd_byte = {3'h0, aux_s};
         default: begin
            rd_byte = 8'h00;
            rd_mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      aw_full_next = aw_full_reg;
      w_full_next = w_full_reg;
      waddr_next = waddr_reg;
      wbyte_next = wbyte_reg;
      wlane_next = wlane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (awvalid && !aw_full_reg) begin
         aw_full_next = 1'b1;
         waddr_next = awaddr;
      end
      if (wvalid && !w_full_reg) begin
         w_full_next = 1'b1;
         wbyte_next = wdata[7:0];
         wlane_next = wstrb[0];
      end
      if (do_write) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = wr_mapped ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rdata_next = {24'h00_0000, rd_byte};
         rresp_next = rd_mapped ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         waddr_reg <= 8'h00;
         wbyte_reg <= 8'h00;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `IOP_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `IOP_RESP_OKAY;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         waddr_reg <= waddr_next;
         wbyte_reg <= wbyte_next;
         wlane_reg <= wlane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register file; a write with lane 0 off is answered but changes nothing
   always_comb begin
      logic we;
      we = do_write && wlane_reg;
      bidir_data_next = bidir_data_reg;
      bidir_port_mode_next = bidir_port_mode_reg;
      aux_port_mode_next = aux_port_mode_reg;
      port_config_next = port_config_reg;
      interrupt_request_next = interrupt_request_reg;
      stop_recovery_next = stop_recovery_reg;
      watchdog_mode_next = watchdog_mode_reg;
      aux_data_next = aux_data_reg;
      timer_out_next = timer_output_line;
      if (we) begin
         unique case (waddr_reg)
            `IOP_OFF_BIDIR_DATA: bidir_data_next = wbyte_reg;
            `IOP_OFF_BIDIR_MODE: bidir_port_mode_next = wbyte_reg;
            `IOP_OFF_AUX_MODE: aux_port_mode_next = wbyte_reg;
            `IOP_OFF_PORT_CFG: port_config_next = wbyte_reg;
            `IOP_OFF_IRQ: interrupt_request_next = wbyte_reg;
            `IOP_OFF_SMR: stop_recovery_next = wbyte_reg;
            `IOP_OFF_WDT: watchdog_mode_next = wbyte_reg;
            `IOP_OFF_AUX_DATA: aux_data_next = wbyte_reg[`IOP_AUXD_OUT_B:`IOP_AUXD_OUT_A];
            default: ;
         endcase
      end
      // Stop recovery resets only the registers that do not survive it
      if (stop_recovery) begin
         bidir_data_next = `IOP_RST_BIDIR_DATA;
         port_config_next = `IOP_RST_PORT_CFG;
         interrupt_request_next = `IOP_RST_IRQ;
         aux_data_next = `IOP_RST_AUX_DATA;
      end
      // A request arriving with a clear still sets its pending flag
      interrupt_request_next[`IOP_IRQ_ZERO] = interrupt_request_next[`IOP_IRQ_ZERO]
                                               | request_line_zero;
      interrupt_request_next[`IOP_IRQ_ONE] = interrupt_request_next[`IOP_IRQ_ONE]
                                              | request_line_one;
      interrupt_request_next[`IOP_IRQ_TWO] = interrupt_request_next[`IOP_IRQ_TWO]
                                              | request_line_two;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bidir_data_reg <= `IOP_RST_BIDIR_DATA;
         bidir_port_mode_reg <= `IOP_RST_BIDIR_MODE;
         aux_port_mode_reg <= `IOP_RST_AUX_MODE;
         port_config_reg <= `IOP_RST_PORT_CFG;
         interrupt_request_reg <= `IOP_RST_IRQ;
         stop_recovery_reg <= `IOP_RST_SMR;
         watchdog_mode_reg <= `IOP_RST_WDT;
         aux_data_reg <= `IOP_RST_AUX_DATA;
         timer_out_reg <= 1'b0;
      end else begin
         bidir_data_reg <= bidir_data_next;
         bidir_port_mode_reg <= bidir_port_mode_next;
         aux_port_mode_reg <= aux_port_mode_next;
         port_config_reg <= port_config_next;
         interrupt_request_reg <= interrupt_request_next;
         stop_recovery_reg <= stop_recovery_next;
         watchdog_mode_reg <= watchdog_mode_next;
         aux_data_reg <= aux_data_next;
         timer_out_reg <= timer_out_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   dir_input_a: assert property (bidir_port_mode_reg[0] |-> !bidir_port_lines_oe[0])
      else $error("input line is driven");
   od_drive_a: assert property (port_config_reg[`IOP_CFG_BIDIR_OD]
      && !bidir_port_mode_reg[3] |-> bidir_port_lines_oe[3] == !bidir_port_lines_out[3])
      else $error("open-drain line drives high");
   aux_od_a: assert property (aux_od && aux_output_a |-> !aux_output_a_oe)
      else $error("open-drain aux output drives high");
   timer_pp_a: assert property (##1 aux_output_timer == $past(timer_output_line))
      else $error("timer output not passed through");
   edge_rise_a: assert property ($rose(a_val) && a_rise |=> request_line_two)
      else $error("selected rising edge missed");
   edge_block_a: assert property ($fell(a_val) && edge_sel == EDGE_RISE_FALL
      |=> !request_line_two)
      else $error("unselected falling edge requested");
   route_zero_a: assert property (request_line_zero |-> $past(b_val) != $past(b_val, 2))
      else $error("request zero without b edge");
   wake_req_a: assert property (analog && $rose(ref_val) |=> request_line_one)
      else $error("wake source did not request");
   route_out_a: assert property (route && !aux_od
      |-> aux_output_a == $past(comparator_a_out, 3))
      else $error("comparator not routed");
   retain_mode_a: assert property (stop_recovery && !do_write
      |=> bidir_port_mode_reg == $past(bidir_port_mode_reg))
      else $error("mode lost on stop recovery");
   sticky_set_a: assert property (request_line_zero |=> interrupt_request_reg[0])
      else $error("pending flag not set");
endmodule

// File: rtl/iop_params.svh
// Register offsets, field positions and reset values of the port block
`ifndef IOP_PARAMS_SVH
`define IOP_PARAMS_SVH

`define IOP_OFF_BIDIR_DATA 8'h00
`define IOP_OFF_BIDIR_MODE 8'h04
`define IOP_OFF_AUX_MODE 8'h08
`define IOP_OFF_PORT_CFG 8'h0C
`define IOP_OFF_IRQ 8'h10
`define IOP_OFF_SMR 8'h14
`define IOP_OFF_WDT 8'h18
`define IOP_OFF_AUX_DATA 8'h1C
`define IOP_OFF_STATUS 8'h20

`define IOP_RST_BIDIR_DATA 8'h00
`define IOP_RST_BIDIR_MODE 8'hFF
`define IOP_RST_AUX_MODE 8'h00
`define IOP_RST_PORT_CFG 8'h00
`define IOP_RST_IRQ 8'h00
`define IOP_RST_SMR 8'h00
`define IOP_RST_WDT 8'h00
`define IOP_RST_AUX_DATA 2'h0

`define IOP_AUXM_ANALOG 1
`define IOP_CFG_BIDIR_OD 0
`define IOP_CFG_AUX_OD 1
`define IOP_CFG_ROUTE 2
`define IOP_IRQ_ZERO 0
`define IOP_IRQ_ONE 1
`define IOP_IRQ_TWO 2
`define IOP_IRQ_SEL_HI 7
`define IOP_IRQ_SEL_LO 6
`define IOP_SMR_SRC_HI 4
`define IOP_SMR_SRC_LO 2
`define IOP_SMR_POL 6
`define IOP_AUXD_OUT_A 4
`define IOP_AUXD_OUT_B 5

`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2

`endif

// File: rtl/iop_pkg.sv
// Types shared by the port block
package iop_pkg;
   typedef logic [7:0] iop_byte_t;
   typedef logic [31:0] iop_word_t;
   typedef enum logic [1:0] {
      EDGE_FALL_FALL,
      EDGE_FALL_RISE,
      EDGE_RISE_FALL,
      EDGE_BOTH
   } iop_edge_sel_t;
endpackage

// File: rtl/iop_sync_hold.sv
// Input keeper followed by a two-flop synchroniser
`timescale 1ns/10ps
module iop_sync_hold #(
   parameter int W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] pin_in,
   input wire logic [W-1:0] driven,
   output logic [W-1:0] level
);
   logic [W-1:0] keep_reg, keep_next;
   logic [W-1:0] meta_reg, sync_reg;

   // An undriven line keeps its last level instead of floating
   always_comb begin
      keep_next = (driven & pin_in) | (~driven & keep_reg);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         keep_reg <= '0;
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         keep_reg <= keep_next;
         meta_reg <= keep_reg;
         sync_reg <= meta_reg;
      end
   end

   assign level = sync_reg;
endmodule

// File: rtl/iop_edge_det.sv
// Edge detector giving a one-cycle registered pulse per selected edge
`timescale 1ns/10ps
module iop_edge_det (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level,
   input wire logic rise_en,
   input wire logic fall_en,
   output logic pulse
);
   logic prev_reg, pulse_reg, pulse_next;

   always_comb begin
      pulse_next = (level & ~prev_reg & rise_en) | (~level & prev_reg & fall_en);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end else begin
         prev_reg <= level;
         pulse_reg <= pulse_next;
      end
   end

   assign pulse = pulse_reg;
endmodule

// File: test/iop_pin_model.sv
// Model of the circuits that drive and sense the port pins
`timescale 1ns/10ps
module iop_pin_model #(
   parameter int W = 8
) (
   input wire logic aclk,
   input wire logic [W-1:0] dev_out,
   input wire logic [W-1:0] dev_oe,
   input wire logic [W-1:0] ext_val,
   input wire logic [W-1:0] ext_drive,
   output logic [W-1:0] level,
   output logic [W-1:0] driven
);
   logic [W-1:0] last_reg = '0;
   // A released line flips every cycle so that only a real keeper can hold it
   assign level = (dev_oe & dev_out) | (~dev_oe & ext_drive & ext_val)
      | (~dev_oe & ~ext_drive & ~last_reg);
   assign driven = dev_oe | ext_drive;
   always_ff @(posedge aclk) begin
      last_reg <= level;
   end
endmodule

// File: test/tb.sv
// Self-checking bench for the port block
`timescale 1ns/10ps
`include "iop_params.svh"
module tb;
   import iop_pkg::*;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic stop_recovery = 1'h0;
   iop_byte_t awaddr = '0, araddr = '0, wake = '0, b_ext = '0, b_edr = '0;
   iop_byte_t b_out, b_oe, b_lvl, b_drv;
   iop_word_t wdata = '0, rdata, d;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [2:0] a_lvl, a_drv, a_ext = 3'h4, a_edr = 3'h7;
   logic cmp_a = 1'h0, cmp_b = 1'h0, t_out = 1'h0;
   logic o_a, o_a_oe, o_b, o_b_oe, o_t, t_in, rq0, rq1, rq2;
   int n0 = 0, n1 = 0, n2 = 0, error_cnt = 0, comparisons = 0, cyc = 0;
   int b0, b1, b2, s;

   iop_ports uut (.aclk(aclk), .aresetn(aresetn), .stop_recovery(stop_recovery),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .bidir_port_lines_in(b_lvl), .bidir_port_lines_driven(b_drv),
      .bidir_port_lines_out(b_out), .bidir_port_lines_oe(b_oe), .aux_in(a_lvl),
      .aux_in_driven(a_drv), .comparator_a_out(cmp_a), .comparator_b_out(cmp_b),
      .wake_src(wake), .aux_output_a(o_a), .aux_output_a_oe(o_a_oe),
      .aux_output_b(o_b), .aux_output_b_oe(o_b_oe), .aux_output_timer(o_t),
      .timer_output_line(t_out), .timer_input_line(t_in),
      .request_line_zero(rq0), .request_line_one(rq1), .request_line_two(rq2));
   iop_pin_model #(.W(8)) bidir_pins (.aclk(aclk), .dev_out(b_out), .dev_oe(b_oe),
      .ext_val(b_ext), .ext_drive(b_edr), .level(b_lvl), .driven(b_drv));
   iop_pin_model #(.W(3)) aux_pins (.aclk(aclk), .dev_out(3'h0), .dev_oe(3'h0),
      .ext_val(a_ext), .ext_drive(a_edr), .level(a_lvl), .driven(a_drv));

   always #25 aclk = ~aclk;
   // Request pulses last one cycle, so each one is counted once
   always @(negedge aclk) begin
      if (rq0 === 1'h1) n0++;
      if (rq1 === 1'h1) n1++;
      if (rq2 === 1'h1) n2++;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input iop_word_t seen, input iop_word_t exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask
   // Ready is sampled mid-cycle, where it is settled, and acted on at the next edge
   task automatic wr(input iop_byte_t a, input iop_byte_t v);
      logic ta, tw;
      ta = 1'h0;
      tw = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(negedge aclk);
         ta = ta | awready;
         tw = tw | wready;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
      end while (!(ta && tw));
      do @(negedge aclk); while (bvalid !== 1'h1);
      rs = bresp;
      @(posedge aclk);
      bready <= 1'h0;
   endtask
   task automatic rd(input iop_byte_t a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(negedge aclk); while (arready !== 1'h1);
      @(posedge aclk);
      arvalid <= 1'h0;
      do @(negedge aclk); while (rvalid !== 1'h1);
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      rready <= 1'h0;
   endtask
   task automatic rdc(input iop_byte_t a, input iop_word_t exp);
      rd(a);
      chk($sformatf("reg %h", a), d, exp);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      rdc(`IOP_OFF_BIDIR_MODE, 32'h0000_00FF);
      rdc(`IOP_OFF_AUX_MODE, 32'h0000_0000);
      rdc(8'h24, 32'h0000_0000);
      chk("unmapped resp", {30'h0, rs}, {30'h0, `IOP_RESP_SLVERR});
      wr(8'h22, 8'h00);
      chk("unaligned wr resp", {30'h0, rs}, {30'h0, `IOP_RESP_SLVERR});
      $display("test reset done");
      wr(`IOP_OFF_BIDIR_MODE, 8'hF0);
      chk("write resp", {30'h0, rs}, {30'h0, `IOP_RESP_OKAY});
      wr(`IOP_OFF_BIDIR_DATA, 8'hA5);
      wt(2);
      chk("bidir oe", b_oe, 32'h0000_000F);
      chk("bidir out", b_out & 8'h0F, 32'h0000_0005);
      wr(`IOP_OFF_PORT_CFG, 8'h01);
      wt(2);
      chk("open drain oe", b_oe, 32'h0000_000A);
      @(posedge aclk);
      b_ext <= 8'h3C;
      b_edr <= 8'hFF;
      wr(`IOP_OFF_BIDIR_MODE, 8'hFF);
      wt(4);
      rdc(`IOP_OFF_BIDIR_DATA, 32'h0000_003C);
      @(posedge aclk);
      b_edr <= 8'h00;
      wt(6);
      rdc(`IOP_OFF_BIDIR_DATA, 32'h0000_003C);
      $display("test bidir done");
      for (s = 0; s < 4; s++) begin
         wr(`IOP_OFF_IRQ, {s[1:0], 6'h00});
         b0 = n0;
         b2 = n2;
         @(posedge aclk);
         a_ext <= 3'h7;
         wt(6);
         chk("rise a", n2 - b2, s >= 2);
         chk("rise b", n0 - b0, s == 1 || s == 3);
         chk("timer in", t_in, 1);
         b0 = n0;
         b2 = n2;
         @(posedge aclk);
         a_ext <= 3'h4;
         wt(6);
         chk("fall a", n2 - b2, s != 2);
         chk("fall b", n0 - b0, s != 1);
      end
      rdc(`IOP_OFF_IRQ, 32'h0000_00C5);
      $display("test edges done");
      wr(`IOP_OFF_AUX_MODE, 8'h02);
      wt(6);
      b0 = n0;
      b2 = n2;
      @(posedge aclk);
      cmp_a <= 1'h1;
      cmp_b <= 1'h1;
      wt(6);
      chk("comp a req", n2 - b2, 1);
      chk("comp b req", n0 - b0, 1);
      rdc(`IOP_OFF_STATUS, 32'h0000_001C);
      b2 = n2;
      @(posedge aclk);
      a_ext <= 3'h5;
      wt(6);
      chk("pin a in analog", n2 - b2, 0);
      wr(`IOP_OFF_AUX_DATA, 8'h10);
      wt(1);
      chk("latch a", o_a, 1);
      chk("latch b", o_b, 0);
      rdc(`IOP_OFF_AUX_DATA, 32'h0000_0017);
      wr(`IOP_OFF_PORT_CFG, 8'h04);
      wt(4);
      chk("routed a", o_a, 1);
      chk("routed b", o_b, 1);
      wr(`IOP_OFF_PORT_CFG, 8'h06);
      @(posedge aclk);
      cmp_b <= 1'h0;
      wt(6);
      chk("od a oe", o_a_oe, 0);
      chk("od b oe", o_b_oe, 1);
      wr(`IOP_OFF_SMR, 8'h4C);
      wt(6);
      b1 = n1;
      @(posedge aclk);
      wake <= 8'h08;
      wt(6);
      chk("wake req", n1 - b1, 1);
      wr(`IOP_OFF_AUX_MODE, 8'h00);
      wt(6);
      b1 = n1;
      @(posedge aclk);
      a_ext <= 3'h0;
      wt(6);
      chk("ref fall req", n1 - b1, 1);
      @(posedge aclk);
      a_edr <= 3'h3;
      t_out <= 1'h1;
      wt(6);
      rdc(`IOP_OFF_STATUS, 32'h0000_0008);
      chk("timer out", o_t, 1);
      $display("test aux done");
      wr(`IOP_OFF_BIDIR_MODE, 8'h0F);
      wr(`IOP_OFF_AUX_MODE, 8'h02);
      wr(`IOP_OFF_WDT, 8'h5A);
      @(posedge aclk);
      stop_recovery <= 1'h1;
      @(posedge aclk);
      stop_recovery <= 1'h0;
      wt(2);
      rdc(`IOP_OFF_BIDIR_MODE, 32'h0000_000F);
      rdc(`IOP_OFF_AUX_MODE, 32'h0000_0002);
      rdc(`IOP_OFF_SMR, 32'h0000_004C);
      rdc(`IOP_OFF_WDT, 32'h0000_005A);
      rdc(`IOP_OFF_PORT_CFG, 32'h0000_0000);
      $display("test stop recovery done");
      close_out();
   end
endmodule
